// file: hdl/rtd_excitation_control.sv
// sensor excitation control registers behind a serial configuration port
// Summary of operation
// R1: on-chip resistor after reset; select bit picks off-chip
// R2: currents are 100uA reference times ratio 1,4,5,6,9,10
// R3: excitation enabled after reset; disable bit turns off
// R4: wire-count bit zero means 4-wire; set means 3/2-wire
// R5: 3-wire: excitation to positive, compensation to negative
// R6: both level fields reset to zero; six levels
// R7: host writes equal levels in 3-wire scheme
// R8: 4-wire: excitation on sensor pin only; compensation off
// R9: host clears current-mode bit before 4-wire use
// R10: one register write updates all fields at once
`timescale 1ns/1ns
module rtd_excitation_control (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // serial configuration port
    input wire logic cfgSclk,
    input wire logic cfgCs_n,
    input wire logic cfgSdi,
    output logic cfgSdo,
    output logic cfgSdoEnable,
    // excitation, amplifier gain and CRC controls; ratios of the 100 uA reference
    output logic offChipResistorSelect,
    output logic excitationEnable,
    output logic [3:0] positivePinRatio,
    output logic [3:0] negativePinRatio,
    output logic [3:0] sensorPinRatio,
    output logic [3:0] amplifierGainCode,
    output logic crcEnable
);
    // reset release
    logic [1:0] rstSync_q;
    logic rstN;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_q <= 2'b00;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    // pin synchronisers, third stage kept for edge detection
    logic [2:0] sclkSync_q;
    logic [1:0] csSync_q;
    logic [1:0] sdiSync_q;
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            sclkSync_q <= 3'b000;
            csSync_q <= 2'b11;
            sdiSync_q <= 2'b00;
        end else begin
            sclkSync_q <= {sclkSync_q[1:0], cfgSclk};
            csSync_q <= {csSync_q[0], cfgCs_n};
            sdiSync_q <= {sdiSync_q[0], cfgSdi};
        end
    end
    logic selected;
    logic sclkRise;
    logic sclkFall;
    assign selected = !csSync_q[1];
    assign sclkRise = sclkSync_q[1] && !sclkSync_q[2];
    assign sclkFall = !sclkSync_q[1] && sclkSync_q[2];

    // frame state
    logic [4:0] bitCount_q, bitCount_d;
    logic [22:0] rxShift_q, rxShift_d;
    logic [15:0] txShift_q, txShift_d;
    logic sdo_q, sdo_d;
    logic sdoEn_q, sdoEn_d;
    logic [15:0] ctlOne_q, ctlOne_d;
    logic [15:0] excGain_q, excGain_d;
    logic [15:0] readData;
    logic [7:0] command;
    logic [23:0] frame;

    // command byte arrives complete on the eighth rising edge
    assign command = {rxShift_q[6:0], sdiSync_q[1]};
    assign frame = {rxShift_q, sdiSync_q[1]};

    always_comb begin
        case (command[3:0])
            rtd_excitation_pkg::ADDR_FRONT_END_CONTROL_ONE: begin
                readData = ctlOne_q;
            end
            rtd_excitation_pkg::ADDR_EXCITATION_GAIN_CONTROL: begin
                readData = excGain_q;
            end
            default: begin
                readData = 16'h0000;
            end
        endcase
    end

    always_comb begin
        bitCount_d = bitCount_q;
        rxShift_d = rxShift_q;
        txShift_d = txShift_q;
        sdo_d = sdo_q;
        sdoEn_d = selected;
        ctlOne_d = ctlOne_q;
        excGain_d = excGain_q;
        if (!selected) begin
            bitCount_d = 5'h00;
            txShift_d = 16'h0000;
            sdo_d = 1'b0;
        end else if (sclkRise &&
            bitCount_q < 5'(rtd_excitation_pkg::FRAME_BITS)) begin
            rxShift_d = frame[22:0];
            bitCount_d = bitCount_q + 5'h01;
            if (bitCount_q == 5'(rtd_excitation_pkg::COMMAND_BITS - 1)) begin
                txShift_d = command[rtd_excitation_pkg::READ_FLAG_BIT] ?
                    readData : 16'h0000;
            end
            // commit the whole word on its last bit
            if (bitCount_q == 5'(rtd_excitation_pkg::FRAME_BITS - 1) &&
                !frame[16 + rtd_excitation_pkg::READ_FLAG_BIT]) begin // R10
                case (frame[19:16])
                    rtd_excitation_pkg::ADDR_FRONT_END_CONTROL_ONE: begin
                        ctlOne_d = frame[15:0] &
                            rtd_excitation_pkg::FRONT_END_CONTROL_ONE_MASK;
                    end
                    rtd_excitation_pkg::ADDR_EXCITATION_GAIN_CONTROL: begin
                        excGain_d = frame[15:0] &
                            rtd_excitation_pkg::EXCITATION_GAIN_CONTROL_MASK;
                    end
                    default: begin
                        ctlOne_d = ctlOne_q;
                    end
                endcase
            end
        end else if (sclkFall &&
            bitCount_q >= 5'(rtd_excitation_pkg::COMMAND_BITS)) begin
            sdo_d = txShift_q[15];
            txShift_d = {txShift_q[14:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            bitCount_q <= 5'h00;
            rxShift_q <= 23'h000000;
            txShift_q <= 16'h0000;
            sdo_q <= 1'b0;
            sdoEn_q <= 1'b0;
            ctlOne_q <= rtd_excitation_pkg::FRONT_END_CONTROL_ONE_RESET; // R3
            excGain_q <=
                rtd_excitation_pkg::EXCITATION_GAIN_CONTROL_RESET; // R6
        end else begin
            bitCount_q <= bitCount_d;
            rxShift_q <= rxShift_d;
            txShift_q <= txShift_d;
            sdo_q <= sdo_d;
            sdoEn_q <= sdoEn_d;
            ctlOne_q <= ctlOne_d;
            excGain_q <= excGain_d;
        end
    end

    // level code to mirror ratio; codes 0 and 7 give no current
    function automatic logic [3:0] levelRatio(input logic [2:0] code);
        case (code)
            3'h1: levelRatio = rtd_excitation_pkg::RATIO_L1;
            3'h2: levelRatio = rtd_excitation_pkg::RATIO_L2;
            3'h3: levelRatio = rtd_excitation_pkg::RATIO_L3;
            3'h4: levelRatio = rtd_excitation_pkg::RATIO_L4;
            3'h5: levelRatio = rtd_excitation_pkg::RATIO_L5;
            3'h6: levelRatio = rtd_excitation_pkg::RATIO_L6;
            default: levelRatio = rtd_excitation_pkg::RATIO_OFF;
        endcase
    endfunction : levelRatio

    // current routing
    logic enable;
    logic threeWire;
    logic [3:0] excRatio;
    logic [3:0] comRatio;
    logic offChip_q, offChip_d;
    logic enable_q, enable_d;
    logic [3:0] posRatio_q, posRatio_d;
    logic [3:0] negRatio_q, negRatio_d;
    logic [3:0] senRatio_q, senRatio_d;
    logic [3:0] gain_q, gain_d;
    logic crc_q, crc_d;

    assign enable =
        !ctlOne_q[rtd_excitation_pkg::EXCITATION_DISABLE_BIT]; // R3
    assign threeWire =
        excGain_q[rtd_excitation_pkg::WIRE_COUNT_SELECT_BIT]; // R4
    assign excRatio = levelRatio(excGain_q[
        rtd_excitation_pkg::EXCITATION_LEVEL_LSB +: 3]); // R2
    assign comRatio = levelRatio(excGain_q[
        rtd_excitation_pkg::COMPENSATION_LEVEL_LSB +: 3]); // R2

    always_comb begin
        offChip_d = excGain_q[rtd_excitation_pkg::OFF_CHIP_RESISTOR_BIT]; // R1
        posRatio_d = rtd_excitation_pkg::RATIO_OFF;
        negRatio_d = rtd_excitation_pkg::RATIO_OFF;
        senRatio_d = rtd_excitation_pkg::RATIO_OFF;
        enable_d = enable;
        gain_d = excGain_q[rtd_excitation_pkg::GAIN_CODE_LSB +: 4];
        crc_d = ctlOne_q[rtd_excitation_pkg::CRC_ENABLE_BIT];
        if (enable && threeWire) begin
            posRatio_d = excRatio; // R5
            negRatio_d = comRatio; // R5
        end else if (enable) begin
            senRatio_d = excRatio; // R8
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            offChip_q <= 1'b0;
            enable_q <= 1'b1;
            posRatio_q <= rtd_excitation_pkg::RATIO_OFF;
            negRatio_q <= rtd_excitation_pkg::RATIO_OFF;
            senRatio_q <= rtd_excitation_pkg::RATIO_OFF;
            gain_q <= 4'h0;
            crc_q <= 1'b0;
        end else begin
            offChip_q <= offChip_d;
            enable_q <= enable_d;
            posRatio_q <= posRatio_d;
            negRatio_q <= negRatio_d;
            senRatio_q <= senRatio_d;
            gain_q <= gain_d;
            crc_q <= crc_d;
        end
    end

    assign cfgSdo = sdo_q;
    assign cfgSdoEnable = sdoEn_q;
    assign offChipResistorSelect = offChip_q;
    assign excitationEnable = enable_q;
    assign positivePinRatio = posRatio_q;
    assign negativePinRatio = negRatio_q;
    assign sensorPinRatio = senRatio_q;
    assign amplifierGainCode = gain_q;
    assign crcEnable = crc_q;
endmodule : rtd_excitation_control

// file: hdl/rtd_excitation_pkg.sv
// constants for the sensor excitation control register bank
package rtd_excitation_pkg;
    // register addresses
    localparam logic [3:0] ADDR_FRONT_END_CONTROL_ONE = 4'h1;
    localparam logic [3:0] ADDR_EXCITATION_GAIN_CONTROL = 4'h5;
    // front_end_control_one fields
    localparam int CRC_ENABLE_BIT = 13;
    localparam int EXCITATION_DISABLE_BIT = 9;
    localparam logic [15:0] FRONT_END_CONTROL_ONE_MASK = 16'h2200;
    localparam logic [15:0] FRONT_END_CONTROL_ONE_RESET = 16'h0000;
    // excitation_gain_control fields
    localparam int WIRE_COUNT_SELECT_BIT = 15;
    localparam int COMPENSATION_LEVEL_LSB = 12;
    localparam int EXCITATION_LEVEL_LSB = 9;
    localparam int OFF_CHIP_RESISTOR_BIT = 8;
    localparam int GAIN_CODE_LSB = 4;
    localparam logic [15:0] EXCITATION_GAIN_CONTROL_MASK = 16'hfff0;
    localparam logic [15:0] EXCITATION_GAIN_CONTROL_RESET = 16'h0000;
    // serial frame layout
    localparam int COMMAND_BITS = 8;
    localparam int FRAME_BITS = 24;
    localparam int READ_FLAG_BIT = 6;
    // mirror reference in microamps, and the ratio set
    localparam int REFERENCE_CURRENT_UA = 100;
    localparam logic [3:0] RATIO_OFF = 4'h0;
    localparam logic [3:0] RATIO_L1 = 4'h1;
    localparam logic [3:0] RATIO_L2 = 4'h4;
    localparam logic [3:0] RATIO_L3 = 4'h5;
    localparam logic [3:0] RATIO_L4 = 4'h6;
    localparam logic [3:0] RATIO_L5 = 4'h9;
    localparam logic [3:0] RATIO_L6 = 4'ha;
endpackage : rtd_excitation_pkg

// file: testbench/rtd_excitation_sva.sv
// assertion checker for the excitation control bank
`timescale 1ns/1ns
module rtd_excitation_sva (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // serial port
    input wire logic cfgCs_n,
    input wire logic cfgSdoEnable,
    // excitation outputs
    input wire logic offChipResistorSelect,
    input wire logic excitationEnable,
    input wire logic [3:0] positivePinRatio,
    input wire logic [3:0] negativePinRatio,
    input wire logic [3:0] sensorPinRatio
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic [11:0] r;
    assign r = {positivePinRatio, negativePinRatio, sensorPinRatio};
    function automatic logic ok(logic [3:0] v);
        return v inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h9, 4'ha};
    endfunction : ok
    chk_ratio_set: assert property (ok(positivePinRatio) &&
        ok(negativePinRatio) && ok(sensorPinRatio))
        else $error("ratio outside set");
    chk_disable_zero: assert property (
        !excitationEnable |-> r == 12'h000)
        else $error("ratio while disabled");
    chk_four_wire: assert property (sensorPinRatio != 4'h0 |->
        positivePinRatio == 4'h0 && negativePinRatio == 4'h0)
        else $error("analog pins driven in 4-wire");
    chk_three_wire: assert property (negativePinRatio != 4'h0 |->
        sensorPinRatio == 4'h0) else $error("sensor pin in 3-wire");
    chk_scheme_excl: assert property (positivePinRatio != 4'h0 |->
        sensorPinRatio == 4'h0) else $error("both schemes at once");
    chk_reset_values: assert property ($rose(reset_n) |->
        !offChipResistorSelect && excitationEnable && r == 12'h000)
        else $error("bad reset values");
    chk_idle_stable: assert property (cfgCs_n [*8] |-> $stable(r) &&
        $stable({offChipResistorSelect, excitationEnable}))
        else $error("output changed without a frame");
    chk_sdo_release: assert property (cfgCs_n [*5] |-> !cfgSdoEnable)
        else $error("data out driven while deselected");
endmodule : rtd_excitation_sva
bind rtd_excitation_control rtd_excitation_sva rtd_excitation_sva_i (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cfgCs_n(cfgCs_n),
    .cfgSdoEnable(cfgSdoEnable),
    .offChipResistorSelect(offChipResistorSelect),
    .excitationEnable(excitationEnable),
    .positivePinRatio(positivePinRatio),
    .negativePinRatio(negativePinRatio),
    .sensorPinRatio(sensorPinRatio)
);

// file: testbench/tb_rtd_excitation_control.sv
// self-checking bench for the excitation control bank
`timescale 1ns/1ns
module tb_rtd_excitation_control;
    typedef struct packed {
        logic [15:0] data;
        logic [3:0] pos;
        logic [3:0] neg;
        logic [3:0] sens;
        logic off;
    } row_s;
    logic core_clk, reset_n, cfgSclk, cfgCs_n, cfgSdi, cfgSdo, cfgSdoEnable;
    logic offChipResistorSelect, excitationEnable, crcEnable;
    logic [3:0] positivePinRatio, negativePinRatio, sensorPinRatio;
    logic [3:0] amplifierGainCode;
    logic [15:0] rd;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    row_s rows [10] = '{'{16'h9300, 4'h1, 4'h1, 4'h0, 1'b1},
        '{16'ha400, 4'h4, 4'h4, 4'h0, 1'b0},
        '{16'hb650, 4'h5, 4'h5, 4'h0, 1'b0},
        '{16'hc800, 4'h6, 4'h6, 4'h0, 1'b0},
        '{16'hda00, 4'h9, 4'h9, 4'h0, 1'b0},
        '{16'hec00, 4'ha, 4'ha, 4'h0, 1'b0},
        '{16'hfeff, 4'h0, 4'h0, 4'h0, 1'b0},
        '{16'h0b00, 4'h0, 4'h0, 4'h9, 1'b1},
        '{16'h3c00, 4'h0, 4'h0, 4'ha, 1'b0},
        '{16'h9100, 4'h0, 4'h1, 4'h0, 1'b1}};
    rtd_excitation_control rtd_excitation_control_i (
        .core_clk(core_clk), .reset_n(reset_n), .cfgSclk(cfgSclk),
        .cfgCs_n(cfgCs_n), .cfgSdi(cfgSdi), .cfgSdo(cfgSdo),
        .cfgSdoEnable(cfgSdoEnable),
        .offChipResistorSelect(offChipResistorSelect),
        .excitationEnable(excitationEnable),
        .positivePinRatio(positivePinRatio),
        .negativePinRatio(negativePinRatio),
        .sensorPinRatio(sensorPinRatio),
        .amplifierGainCode(amplifierGainCode), .crcEnable(crcEnable));
    task automatic chk(input string what, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // n bits of a frame from the top; last 16 bits of data out land in rd
    task automatic frame(input logic [23:0] f, input int n = 24);
        cfgCs_n = 1'b0;
        repeat (5) @(negedge core_clk);
        chk("sdo enable", {15'h0000, cfgSdoEnable}, 16'h0001);
        for (int i = 23; i >= 24 - n; i--) begin
            cfgSdi = f[i];
            repeat (5) @(negedge core_clk);
            rd = {rd[14:0], cfgSdo};
            cfgSclk = 1'b1;
            repeat (5) @(negedge core_clk);
            cfgSclk = 1'b0;
        end
        repeat (5) @(negedge core_clk);
        cfgCs_n = 1'b1;
        repeat (8) @(negedge core_clk);
        chk("sdo release", {15'h0000, cfgSdoEnable}, 16'h0000);
    endtask : frame
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        reset_n = 1'b0;
        cfgSclk = 1'b0;
        cfgCs_n = 1'b1;
        cfgSdi = 1'b0;
        repeat (16) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (6) @(negedge core_clk);
        chk("reset outs", {1'b0, excitationEnable, crcEnable, positivePinRatio,
            negativePinRatio, sensorPinRatio, offChipResistorSelect},
            16'h4000);
        frame({8'h45, 16'h0000});
        chk("reset reg5", rd, 16'h0000);
        frame({8'h02, 16'h0000});
        foreach (rows[k]) begin
            frame({8'h05, rows[k].data});
            chk("routing", {3'h0, positivePinRatio, negativePinRatio,
                sensorPinRatio, offChipResistorSelect}, {3'h0, rows[k].pos,
                rows[k].neg, rows[k].sens, rows[k].off});
            chk("gain", {12'h000, amplifierGainCode},
                {12'h000, rows[k].data[7:4]});
            frame({8'h45, 16'h0000});
            chk("readback", rd, rows[k].data &
                rtd_excitation_pkg::EXCITATION_GAIN_CONTROL_MASK);
        end
        frame({8'h01, 16'hffff});
        chk("disabled", {1'b0, excitationEnable, crcEnable, positivePinRatio,
            negativePinRatio, sensorPinRatio, offChipResistorSelect},
            16'h2001);
        frame({8'h41, 16'h0000});
        chk("reg1", rd, 16'h2200);
        frame({8'h01, 16'h0000});
        frame({8'h07, 16'hffff});
        chk("enabled", {1'b0, excitationEnable, crcEnable, positivePinRatio,
            negativePinRatio, sensorPinRatio, offChipResistorSelect},
            16'h4021);
        frame({8'h47, 16'h0000});
        chk("unmapped", rd, 16'h0000);
        frame({8'h05, 16'h0b00}, 12);
        chk("cut frame", {1'b0, excitationEnable, crcEnable, positivePinRatio,
            negativePinRatio, sensorPinRatio, offChipResistorSelect},
            16'h4021);
        reset_n = 1'b0;
        repeat (2) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (6) @(negedge core_clk);
        chk("rereset", {1'b0, excitationEnable, crcEnable, positivePinRatio,
            negativePinRatio, sensorPinRatio, offChipResistorSelect},
            16'h4000);
        end_sim();
    end
endmodule : tb_rtd_excitation_control
